// ---- pkg/pin_irq_pkg.sv ----
// Purpose: Constants shared by the pin change interrupt block
// Assumes: 32-bit APB with 12-bit byte addresses, one register per aligned word
// Notes:   Register index times four gives the byte address
`default_nettype none

package pin_irq_pkg;

  localparam int unsigned CHAN_W    = 8;
  localparam int unsigned PORT_CNT  = 6;
  localparam int unsigned SEL_W     = 3;
  localparam int unsigned ADDR_W    = 12;
  localparam int unsigned DATA_W    = 32;

  // Register indices
  localparam logic [7:0] IDX_PORT_SELECT_CTRL  = 8'hE9;
  localparam logic [7:0] IDX_LOW_FALL_ENABLE   = 8'hEA;
  localparam logic [7:0] IDX_HIGH_RISE_ENABLE  = 8'hEB;
  localparam logic [7:0] IDX_CHANNEL_FLAGS     = 8'hEC;
  localparam logic [7:0] IDX_TRIGGER_TYPE_CTRL = 8'hED;

  // Byte addresses
  localparam logic [ADDR_W-1:0] ADDR_PORT_SELECT_CTRL  = {2'b00, IDX_PORT_SELECT_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_LOW_FALL_ENABLE   = {2'b00, IDX_LOW_FALL_ENABLE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_HIGH_RISE_ENABLE  = {2'b00, IDX_HIGH_RISE_ENABLE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CHANNEL_FLAGS     = {2'b00, IDX_CHANNEL_FLAGS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TRIGGER_TYPE_CTRL = {2'b00, IDX_TRIGGER_TYPE_CTRL, 2'b00};

  // Reset values
  localparam logic [SEL_W-1:0]  RST_PORT_SELECT  = 3'h0;
  localparam logic [CHAN_W-1:0] RST_LOW_FALL     = 8'h00;
  localparam logic [CHAN_W-1:0] RST_HIGH_RISE    = 8'h00;
  localparam logic [CHAN_W-1:0] RST_TRIGGER_TYPE = 8'h00;
  localparam logic [CHAN_W-1:0] RST_FLAGS        = 8'h00;
  localparam logic [CHAN_W-1:0] RST_PIN_PREV     = 8'hFF;

  // Highest valid port code, and what channels see under a reserved code
  localparam logic [SEL_W-1:0]  SEL_MAX          = 3'h5;
  localparam logic [CHAN_W-1:0] IDLE_PINS        = 8'hFF;

  localparam logic [DATA_W-1:0] RDATA_NONE       = 32'h0000_0000;

endpackage

`default_nettype wire

// ---- hdl/pin_channel.sv ----
// Purpose: One detection channel with its event flag
// Assumes: Pin and its previous sample are synchronous to clk_sys
// Notes:   Edge flags are sticky, level flags follow the pin
`default_nettype none

module pin_channel
  import pin_irq_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Pin samples
  input  wire logic pin,
  input  wire logic pin_prev,
  // Channel controls
  input  wire logic edge_mode,
  input  wire logic fall_en,
  input  wire logic rise_en,
  input  wire logic clear_req,
  // Event flag
  output var  logic flag_q
);

  logic hit_level;
  logic hit_edge;
  logic flag_d;

  assign hit_level = (fall_en & ~pin) | (rise_en & pin);
  assign hit_edge  = (fall_en & pin_prev & ~pin)
                   | (rise_en & ~pin_prev & pin);
  assign flag_d    = edge_mode ? (hit_edge | (flag_q & ~clear_req))
                               : hit_level;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_fall_edge;
    edge_mode && fall_en && pin_prev && !pin |=> flag_q;
  endproperty
  a_fall_edge: assert property (p_fall_edge) else $error("falling edge missed");

  property p_rise_edge;
    edge_mode && rise_en && !pin_prev && pin |=> flag_q;
  endproperty
  a_rise_edge: assert property (p_rise_edge) else $error("rising edge missed");

  property p_edge_hold;
    edge_mode && flag_q && !clear_req |=> flag_q;
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge flag lost");

  property p_edge_quiet;
    edge_mode && !flag_q && (pin == pin_prev) |=> !flag_q;
  endproperty
  a_edge_quiet: assert property (p_edge_quiet) else $error("flag set with no edge");

  property p_level_track;
    !edge_mode |=> flag_q == (($past(fall_en) && !$past(pin)) || ($past(rise_en) && $past(pin)));
  endproperty
  a_level_track: assert property (p_level_track) else $error("level flag wrong");

endmodule

`default_nettype wire

// ---- hdl/pin_change_interrupt.sv ----
// Purpose: Eight-channel pin change interrupt detector behind an APB slave
// Assumes: Pins synchronous to clk_sys; zero-wait APB with read data registered in setup
// Notes:   Registers at byte address four times their index
//
// Added by the designer: register access over APB.
`default_nettype none

module pin_change_interrupt
  import pin_irq_pkg::*;
#(
  parameter int unsigned NUM_CHAN  = CHAN_W,
  parameter int unsigned NUM_PORTS = PORT_CNT
) (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [ADDR_W-1:0]            paddr,
  input  wire logic [DATA_W-1:0]            pwdata,
  input  wire logic [3:0]                   pstrb,
  output var  logic [DATA_W-1:0]            prdata,
  output var  logic                         pready,
  output var  logic                         pslverr,
  // Port pins, port n on bits 8n+7..8n
  input  wire logic [NUM_PORTS*NUM_CHAN-1:0] port_pins,
  // Interrupt and wake
  output var  logic                         pin_irq,
  output var  logic                         wake_req
);

  logic [SEL_W-1:0]    watched_port_code_q;
  logic [NUM_CHAN-1:0] low_fall_enable_q;
  logic [NUM_CHAN-1:0] high_rise_enable_q;
  logic [NUM_CHAN-1:0] trigger_type_ctrl_q;
  logic [NUM_CHAN-1:0] pin_prev_q;
  logic [NUM_CHAN-1:0] channel_flags;
  logic [DATA_W-1:0]   prdata_q;
  logic [DATA_W-1:0]   prdata_d;

  logic                setup;
  logic                access;
  logic                hit_sel;
  logic                hit_fall;
  logic                hit_rise;
  logic                hit_flags;
  logic                hit_type;
  logic                hit_any;
  logic                wr_ok;
  logic                sel_ok;
  logic [5:0]          port_base;
  logic [NUM_CHAN-1:0] chan_in;
  logic [NUM_CHAN-1:0] flag_clear;
  logic [NUM_CHAN-1:0] level_hit;
  logic                wr_sel;
  logic                wr_fall;
  logic                wr_rise;
  logic                wr_type;
  logic                wr_flags;

  // Bus phases and address decode
  assign setup     = psel & ~penable;
  assign access    = psel & penable;
  assign hit_sel   = paddr == ADDR_PORT_SELECT_CTRL;
  assign hit_fall  = paddr == ADDR_LOW_FALL_ENABLE;
  assign hit_rise  = paddr == ADDR_HIGH_RISE_ENABLE;
  assign hit_flags = paddr == ADDR_CHANNEL_FLAGS;
  assign hit_type  = paddr == ADDR_TRIGGER_TYPE_CTRL;
  assign hit_any   = hit_sel | hit_fall | hit_rise | hit_flags | hit_type;
  assign wr_ok     = access & pwrite & hit_any & pstrb[0];

  // Write strobes, one per register
  assign wr_sel    = wr_ok & hit_sel;
  assign wr_fall   = wr_ok & hit_fall;
  assign wr_rise   = wr_ok & hit_rise;
  assign wr_type   = wr_ok & hit_type;
  assign wr_flags  = wr_ok & hit_flags;

  assign pready    = 1'b1;
  assign pslverr   = access & ~hit_any;
  assign prdata    = prdata_q;

  // Read mux, sampled in the setup cycle
  always_comb begin
    if (hit_sel) begin
      prdata_d = {{(DATA_W-SEL_W){1'b0}}, watched_port_code_q};
    end else if (hit_fall) begin
      prdata_d = {{(DATA_W-NUM_CHAN){1'b0}}, low_fall_enable_q};
    end else if (hit_rise) begin
      prdata_d = {{(DATA_W-NUM_CHAN){1'b0}}, high_rise_enable_q};
    end else if (hit_flags) begin
      prdata_d = {{(DATA_W-NUM_CHAN){1'b0}}, channel_flags};
    end else if (hit_type) begin
      prdata_d = {{(DATA_W-NUM_CHAN){1'b0}}, trigger_type_ctrl_q};
    end else begin
      prdata_d = RDATA_NONE;
    end
  end

  // Port selection
  assign sel_ok    = watched_port_code_q <= SEL_MAX;
  assign port_base = {watched_port_code_q, 3'b000};
  assign chan_in   = sel_ok ? port_pins[port_base +: NUM_CHAN] : IDLE_PINS;

  // Writing 0 to a flag bit clears it; only edge-mode channels honour it
  assign flag_clear = wr_flags ? ~pwdata[NUM_CHAN-1:0] : '0;
  // Level view of all channels, for the checks
  assign level_hit  = (low_fall_enable_q & ~chan_in) | (high_rise_enable_q & chan_in);

  // Control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      watched_port_code_q <= RST_PORT_SELECT;
    end else if (wr_sel) begin
      watched_port_code_q <= pwdata[SEL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_fall_enable_q <= RST_LOW_FALL;
    end else if (wr_fall) begin
      low_fall_enable_q <= pwdata[NUM_CHAN-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      high_rise_enable_q <= RST_HIGH_RISE;
    end else if (wr_rise) begin
      high_rise_enable_q <= pwdata[NUM_CHAN-1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      trigger_type_ctrl_q <= RST_TRIGGER_TYPE;
    end else if (wr_type) begin
      trigger_type_ctrl_q <= pwdata[NUM_CHAN-1:0];
    end
  end

  // Previous pin sample for edge detection
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_prev_q <= RST_PIN_PREV;
    end else begin
      pin_prev_q <= chan_in;
    end
  end

  // Read data register, loaded in the setup cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q <= RDATA_NONE;
    end else if (setup) begin
      prdata_q <= prdata_d;
    end
  end

  // One detector per channel, each flag one bit of the register
  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    pin_channel u_chan (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .pin       (chan_in[i]),
      .pin_prev  (pin_prev_q[i]),
      .edge_mode (trigger_type_ctrl_q[i]),
      .fall_en   (low_fall_enable_q[i]),
      .rise_en   (high_rise_enable_q[i]),
      .clear_req (flag_clear[i]),
      .flag_q    (channel_flags[i])
    );
  end

  assign pin_irq  = |channel_flags;
  assign wake_req = pin_irq;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_port_route;
    sel_ok |-> chan_in == port_pins[port_base +: NUM_CHAN];
  endproperty
  a_port_route: assert property (p_port_route) else $error("wrong port routed");

  property p_port_reserved;
    watched_port_code_q > SEL_MAX |-> chan_in == IDLE_PINS;
  endproperty
  a_port_reserved: assert property (p_port_reserved) else $error("reserved code routed");

  property p_reset_values;
    $past(rst) |-> watched_port_code_q == RST_PORT_SELECT && trigger_type_ctrl_q == '0
                   && high_rise_enable_q == '0;
  endproperty
  a_reset_values: assert property (@(posedge clk_sys) p_reset_values)
    else $error("control not zero after reset");

  property p_irq_any;
    pin_irq == (channel_flags != '0);
  endproperty
  a_irq_any: assert property (p_irq_any) else $error("irq not tied to flags");

  property p_wake;
    pin_irq |-> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("event gave no wake");

  property p_write_enable;
    wr_ok && hit_fall |=> low_fall_enable_q == $past(pwdata[NUM_CHAN-1:0]);
  endproperty
  a_write_enable: assert property (p_write_enable) else $error("enable write lost");

  property p_write_type;
    wr_ok && hit_type |=> trigger_type_ctrl_q == $past(pwdata[NUM_CHAN-1:0]);
  endproperty
  a_write_type: assert property (p_write_type) else $error("type write lost");

  property p_level_no_write;
    wr_flags && trigger_type_ctrl_q == '0
      |=> channel_flags == $past(level_hit);
  endproperty
  a_level_no_write: assert property (p_level_no_write) else $error("level flag written");

  property p_flag_clear;
    wr_flags && trigger_type_ctrl_q == '1 && chan_in == pin_prev_q
      |=> channel_flags == $past(channel_flags & pwdata[NUM_CHAN-1:0]);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");

  property p_unmapped;
    access && !hit_any |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");

  property p_read_back;
    setup && hit_flags ##1 access |-> prdata[NUM_CHAN-1:0] == $past(channel_flags);
  endproperty
  a_read_back: assert property (p_read_back) else $error("flag read wrong");

  property p_write_rise;
    wr_rise |=> high_rise_enable_q == $past(pwdata[NUM_CHAN-1:0]);
  endproperty
  a_write_rise: assert property (p_write_rise) else $error("rise enable write lost");

  property p_write_sel;
    wr_sel |=> watched_port_code_q == $past(pwdata[SEL_W-1:0]);
  endproperty
  a_write_sel: assert property (p_write_sel) else $error("port select write lost");

  property p_strobe_off;
    access && pwrite && !pstrb[0]
      |=> $stable(low_fall_enable_q) && $stable(high_rise_enable_q)
          && $stable(trigger_type_ctrl_q) && $stable(watched_port_code_q);
  endproperty
  a_strobe_off: assert property (p_strobe_off) else $error("masked write took effect");

  property p_bus_quiet;
    !access |-> !pslverr;
  endproperty
  a_bus_quiet: assert property (p_bus_quiet) else $error("error outside access phase");

  property p_read_upper;
    access |-> prdata[DATA_W-1:NUM_CHAN] == '0;
  endproperty
  a_read_upper: assert property (p_read_upper) else $error("read data upper bits set");

  property p_prdata_hold;
    !rst && !setup |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved outside setup");

  property p_irq_sticky;
    pin_irq && !wr_flags && trigger_type_ctrl_q == '1 |=> pin_irq;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("edge request dropped");

  property p_prev_follow;
    !rst |=> pin_prev_q == $past(chan_in);
  endproperty
  a_prev_follow: assert property (p_prev_follow) else $error("previous sample stale");

  c_edge_event: cover property (trigger_type_ctrl_q[0] && channel_flags[0]);
  c_level_event: cover property (!trigger_type_ctrl_q[1] && channel_flags[1]);
  c_clear_flags: cover property (pin_irq ##1 wr_ok && hit_flags ##1 !pin_irq);
  c_port5: cover property (watched_port_code_q == SEL_MAX && pin_irq);
  c_masked_write: cover property (access && pwrite && !pstrb[0]);

endmodule

`default_nettype wire

// ---- dv/keypad_model.sv ----
// Purpose: Keypad model driving the six pin ports
// Assumes: Pressed keys pull a pin low; released pins sit high on pull-ups
// Notes:   Pins change only just after a rising clk_sys edge
`default_nettype none

module keypad_model
  import pin_irq_pkg::*;
(
  // Clock
  input  wire logic                       clk_sys,
  // Key state from the bench
  input  wire logic [PORT_CNT*CHAN_W-1:0] key_down,
  // Port pins
  output var  logic [PORT_CNT*CHAN_W-1:0] port_pins
);
  timeunit 1ns;
  timeprecision 1ns;

  // Released keys return the pin to the pull-up level
  initial begin
    port_pins = '1;
    forever begin
      @(posedge clk_sys);
      port_pins <= ~key_down;
    end
  end
endmodule

`default_nettype wire

// ---- dv/pin_change_interrupt_tb_top.sv ----
// Purpose: Self-checking bench for the pin change interrupt block
// Assumes: Zero-wait APB slave, keypad model on the port pins
// Notes:   Flags are read back over APB after the pins settle
`default_nettype none

module pin_change_interrupt_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pin_irq_pkg::*;

  logic              clk_sys;
  logic              rst;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [47:0]       port_pins;
  logic [47:0]       key_down;
  logic              pin_irq;
  logic              wake_req;
  logic [31:0]       rd_q;
  logic              err_q;
  int                error_cnt;
  int                n_compared;

  pin_change_interrupt uut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_pins(port_pins), .pin_irq(pin_irq), .wake_req(wake_req)
  );

  keypad_model keys (.clk_sys(clk_sys), .key_down(key_down), .port_pins(port_pins));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input string n, input logic [ADDR_W-1:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd_q);
  endtask

  task automatic press(input int k, input logic v);
    key_down[k] <= v;
    repeat (4) @(posedge clk_sys);
  endtask

  task automatic irq_chk(input logic e);
    chk("pin_irq", 32'(e), 32'(pin_irq));
    chk("wake_req", 32'(e), 32'(wake_req));
  endtask

  task automatic print_verdict;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    print_verdict();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    key_down = '0;
    error_cnt = 0;
    n_compared = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // Reset values
    rd("port_sel", ADDR_PORT_SELECT_CTRL, 32'h0);
    rd("high_rise", ADDR_HIGH_RISE_ENABLE, 32'h0);
    rd("trig_type", ADDR_TRIGGER_TYPE_CTRL, 32'h0);
    rd("low_fall", ADDR_LOW_FALL_ENABLE, 32'h0);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h0);
    irq_chk(1'b0);
    // Unmapped address is refused
    apb(1'b1, 12'h3B8, 32'hFF);
    rd("unmapped", 12'h3B8, 32'h0);
    chk("pslverr", 32'h1, 32'(err_q));
    apb(1'b1, ADDR_PORT_SELECT_CTRL, 32'hFF);
    rd("port_sel", ADDR_PORT_SELECT_CTRL, 32'h7);
    apb(1'b1, ADDR_PORT_SELECT_CTRL, 32'h0);
    // Level mode, high enables on idle-high pins
    apb(1'b1, ADDR_HIGH_RISE_ENABLE, 32'hA5);
    rd("high_rise", ADDR_HIGH_RISE_ENABLE, 32'hA5);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'hA5);
    irq_chk(1'b1);
    apb(1'b1, ADDR_CHANNEL_FLAGS, 32'h0);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'hA5);
    apb(1'b1, ADDR_HIGH_RISE_ENABLE, 32'h0);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h0);
    irq_chk(1'b0);
    // Level mode, low enable follows the inverted pin
    apb(1'b1, ADDR_LOW_FALL_ENABLE, 32'h08);
    press(3, 1'b1);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h08);
    irq_chk(1'b1);
    press(3, 1'b0);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h0);
    apb(1'b1, ADDR_HIGH_RISE_ENABLE, 32'h08);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h08);
    press(3, 1'b1);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h08);
    press(3, 1'b0);
    // Edge mode on port 2
    apb(1'b1, ADDR_LOW_FALL_ENABLE, 32'h11);
    apb(1'b1, ADDR_HIGH_RISE_ENABLE, 32'h12);
    apb(1'b1, ADDR_TRIGGER_TYPE_CTRL, 32'hFF);
    apb(1'b1, ADDR_PORT_SELECT_CTRL, 32'h2);
    apb(1'b1, ADDR_CHANNEL_FLAGS, 32'h0);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h0);
    key_down[17] <= 1'b1;
    press(16, 1'b1);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h01);
    key_down[17] <= 1'b0;
    press(16, 1'b0);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h03);
    press(0, 1'b1);
    press(0, 1'b0);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h03);
    apb(1'b1, ADDR_CHANNEL_FLAGS, 32'hFE);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h02);
    irq_chk(1'b1);
    apb(1'b1, ADDR_CHANNEL_FLAGS, 32'h0);
    irq_chk(1'b0);
    // Both edges on one channel
    press(20, 1'b1);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h10);
    apb(1'b1, ADDR_CHANNEL_FLAGS, 32'h0);
    press(20, 1'b0);
    rd("flags", ADDR_CHANNEL_FLAGS, 32'h10);
    // Every port code, reserved ones see no events
    apb(1'b1, ADDR_LOW_FALL_ENABLE, 32'h80);
    apb(1'b1, ADDR_HIGH_RISE_ENABLE, 32'h0);
    for (int p = 0; p < 8; p++) begin
      apb(1'b1, ADDR_PORT_SELECT_CTRL, 32'(p));
      apb(1'b1, ADDR_CHANNEL_FLAGS, 32'h0);
      press((p < 6) ? 8 * p + 7 : 7, 1'b1);
      rd("flags", ADDR_CHANNEL_FLAGS, (p < 6) ? 32'h80 : 32'h0);
      press((p < 6) ? 8 * p + 7 : 7, 1'b0);
    end
    // Write with byte 0 masked is ignored
    pstrb <= 4'hE;
    apb(1'b1, ADDR_LOW_FALL_ENABLE, 32'hFF);
    pstrb <= 4'hF;
    rd("low_fall", ADDR_LOW_FALL_ENABLE, 32'h80);
    // Reset in mid-run returns the controls to zero
    apb(1'b1, ADDR_HIGH_RISE_ENABLE, 32'h3C);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd("port_sel", ADDR_PORT_SELECT_CTRL, 32'h0);
    rd("high_rise", ADDR_HIGH_RISE_ENABLE, 32'h0);
    rd("trig_type", ADDR_TRIGGER_TYPE_CTRL, 32'h0);
    irq_chk(1'b0);
    print_verdict();
  end
endmodule

`default_nettype wire
